// ==== rtl/abx_exec_unit.sv ====
// Add, AND and bit clear/set execute unit with register file
// Function
// RULE1: Instructions decode as 14-bit words: opcode then operand fields.
// RULE2: Add literal to accumulator in one cycle, updating all flags.
// RULE3: Add accumulator and register 00h..5Fh in one cycle, all flags.
// RULE4: Destination bit 0 writes accumulator, 1 writes the register.
// RULE5: AND literal with accumulator into accumulator, zero flag only.
// RULE6: AND accumulator with register, route by destination, zero flag only.
// RULE7: Clear selected bit of register 00h..3Fh, flags unchanged.
// RULE8: Set selected bit of register 00h..3Fh, flags unchanged.
// RULE9: Carry from bit 7, half carry from bit 3, zero on zero result.
`timescale 1ns/1ps
`default_nettype none
`include "abx_params.svh"
module abx_exec_unit
  import abx_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Instruction, one per cycle
  input wire logic instrValid,
  input wire abx_word_t instr,
  // Architectural state
  output logic [7:0] acc,
  output logic carryFlag,
  output logic halfCarryFlag,
  output logic zeroFlag,
  // Register file read-back
  input wire logic [6:0] peekAddr,
  output logic [7:0] peekData,
  // Decode status
  output logic illegal
);
  abx_dec_if dIf();
  abx_byte_t acc_r;
  logic carry_r, half_r, zero_r;
  abx_byte_t regFile [0:95];
  abx_byte_t peek_r;
  abx_byte_t operand, result;
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic addrOk, doOp, wrAcc, wrReg, wrArith, wrZero;

  abx_decoder uDec (
    .instr(instr),
    .d(dIf.dec)
  );

  function automatic logic is_add(input abx_op_e op);
    is_add = (op == ABX_ADD_LIT) || (op == ABX_ADD_REG);
  endfunction

  function automatic logic is_bitop(input abx_op_e op);
    is_bitop = (op == ABX_CLR_BIT) || (op == ABX_SET_BIT);
  endfunction

  // Address range checks; see RULE3 see RULE7
  always_comb begin
    addrOk = 1'b1;
    if (dIf.op == ABX_ADD_REG || dIf.op == ABX_AND_REG) begin
      addrOk = dIf.addr <= `ABX_REG_LAST;
    end else if (is_bitop(dIf.op)) begin
      addrOk = dIf.addr[5:0] <= `ABX_BREG_LAST;
    end
  end

  assign doOp = instrValid && (dIf.op != ABX_NONE) && addrOk;
  assign illegal = instrValid && !doOp;

  always_comb begin
    operand = regFile[dIf.addr];
    if (dIf.op == ABX_ADD_LIT || dIf.op == ABX_AND_LIT) begin
      operand = dIf.lit;
    end
  end

  // Carry out of bit 7 and bit 3; see RULE9
  assign sum = {1'b0, acc_r} + {1'b0, operand};
  assign lowSum = {1'b0, acc_r[3:0]} + {1'b0, operand[3:0]};

  always_comb begin
    result = operand;
    case (dIf.op)
      ABX_ADD_LIT, ABX_ADD_REG: result = sum[7:0];
      ABX_AND_LIT, ABX_AND_REG: result = acc_r & operand;
      ABX_CLR_BIT: result = operand & ~(8'h01 << dIf.bitIdx);
      ABX_SET_BIT: result = operand | (8'h01 << dIf.bitIdx);
      default: result = operand;
    endcase
  end

  // Destination routing; see RULE4
  always_comb begin
    wrAcc = 1'b0;
    wrReg = 1'b0;
    case (dIf.op)
      ABX_ADD_LIT, ABX_AND_LIT: wrAcc = doOp;
      ABX_ADD_REG, ABX_AND_REG: begin
        wrAcc = doOp && !dIf.dest;
        wrReg = doOp && dIf.dest;
      end
      ABX_CLR_BIT, ABX_SET_BIT: wrReg = doOp;
      default: begin
        wrAcc = 1'b0;
        wrReg = 1'b0;
      end
    endcase
  end

  assign wrArith = doOp && is_add(dIf.op);
  assign wrZero = doOp && !is_bitop(dIf.op);

  // Accumulator; see RULE2 see RULE5
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_r <= `ABX_ACC_RESET;
    end else if (wrAcc) begin
      acc_r <= result;
    end
  end

  // Carry flags only on adds; see RULE2 see RULE3 see RULE9
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      carry_r <= 1'b0;
      half_r <= 1'b0;
    end else if (wrArith) begin
      carry_r <= sum[8];
      half_r <= lowSum[4];
    end
  end

  // Zero flag on add and AND, never on bit ops; see RULE5 see RULE6
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zero_r <= 1'b0;
    end else if (wrZero) begin
      zero_r <= (result == 8'h00);
    end
  end

  // Register file write; see RULE4 see RULE7 see RULE8
  genvar gi;
  generate
    for (gi = 0; gi < 96; gi++) begin : gReg
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          regFile[gi] <= `ABX_REG_RESET;
        end else if (wrReg && dIf.addr == 7'(gi)) begin
          regFile[gi] <= result;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      peek_r <= 8'h00;
    end else if (peekAddr <= `ABX_REG_LAST) begin
      peek_r <= regFile[peekAddr];
    end else begin
      peek_r <= 8'h00;
    end
  end

  assign acc = acc_r;
  assign carryFlag = carry_r;
  assign halfCarryFlag = half_r;
  assign zeroFlag = zero_r;
  assign peekData = peek_r;

  property p_add_flags;
    @(posedge clock) disable iff (rst)
    wrArith |=> carryFlag == $past(sum[8])
      && halfCarryFlag == $past(lowSum[4]);
  endproperty
  a_add_flags: assert property (p_add_flags) // see RULE9
    else $error("add flags wrong");

  property p_add_lit;
    @(posedge clock) disable iff (rst)
    doOp && dIf.op == ABX_ADD_LIT |=>
      acc == 8'($past(acc) + $past(dIf.lit));
  endproperty
  a_add_lit: assert property (p_add_lit) // see RULE2
    else $error("literal add wrong");

  property p_add_reg_range;
    @(posedge clock) disable iff (rst)
    instrValid && dIf.op == ABX_ADD_REG && dIf.addr > `ABX_REG_LAST
      |-> illegal;
  endproperty
  a_add_reg_range: assert property (p_add_reg_range) // see RULE3
    else $error("out of range add accepted");

  property p_dest_zero;
    @(posedge clock) disable iff (rst)
    doOp && dIf.op == ABX_ADD_REG && !dIf.dest |=> acc == $past(sum[7:0]);
  endproperty
  a_dest_zero: assert property (p_dest_zero) // see RULE4
    else $error("dest 0 not to accumulator");

  property p_and_lit;
    @(posedge clock) disable iff (rst)
    doOp && dIf.op == ABX_AND_LIT |=>
      acc == ($past(acc) & $past(dIf.lit)) && $stable(carryFlag)
      && zeroFlag == (acc == 8'h00);
  endproperty
  a_and_lit: assert property (p_and_lit) // see RULE5
    else $error("literal AND wrong");

  property p_and_reg_dest1;
    @(posedge clock) disable iff (rst)
    doOp && dIf.op == ABX_AND_REG && dIf.dest |=>
      $stable(acc) && $stable(halfCarryFlag);
  endproperty
  a_and_reg_dest1: assert property (p_and_reg_dest1) // see RULE6
    else $error("AND to register touched accumulator");

  property p_clr_bit;
    @(posedge clock) disable iff (rst)
    doOp && dIf.op == ABX_CLR_BIT |=>
      $stable(zeroFlag) && $stable(carryFlag) && $stable(acc);
  endproperty
  a_clr_bit: assert property (p_clr_bit) // see RULE7
    else $error("bit clear changed flags");

  property p_set_bit;
    @(posedge clock) disable iff (rst)
    doOp && dIf.op == ABX_SET_BIT |->
      result[dIf.bitIdx] && $countones(result ^ operand) <= 1;
  endproperty
  a_set_bit: assert property (p_set_bit) // see RULE8
    else $error("bit set wrong");

  property p_decode;
    @(posedge clock) disable iff (rst)
    instr[13:8] == `ABX_OP_ADD_LIT |-> dIf.op == ABX_ADD_LIT;
  endproperty
  a_decode: assert property (p_decode) // see RULE1
    else $error("decode wrong");
endmodule
`default_nettype wire

// ==== rtl/abx_params.svh ====
// Constants for the add and bit-set execute unit
`ifndef ABX_PARAMS_SVH
`define ABX_PARAMS_SVH
`define ABX_OP_ADD_LIT 6'h1c
`define ABX_OP_ADD_REG 6'h07
`define ABX_OP_AND_LIT 6'h1b
`define ABX_OP_AND_REG 6'h05
`define ABX_OP_CLR_BIT 5'h08
`define ABX_OP_SET_BIT 5'h09
`define ABX_REG_LAST 7'h5f
`define ABX_BREG_LAST 6'h3f
`define ABX_ACC_RESET 8'h00
`define ABX_REG_RESET 8'h00
`endif

// ==== rtl/abx_pkg.sv ====
// Types for the add and bit-set execute unit
package abx_pkg;
  typedef enum logic [2:0] {
    ABX_NONE, ABX_ADD_LIT, ABX_ADD_REG, ABX_AND_LIT, ABX_AND_REG,
    ABX_CLR_BIT, ABX_SET_BIT
  } abx_op_e;
  typedef logic [13:0] abx_word_t;
  typedef logic [7:0] abx_byte_t;
endpackage

// ==== rtl/abx_dec_if.sv ====
// Decoded instruction fields passed from decoder to executer
`timescale 1ns/1ps
`default_nettype none
interface abx_dec_if;
  import abx_pkg::*;
  abx_op_e op;
  logic dest;
  logic [6:0] addr;
  logic [2:0] bitIdx;
  abx_byte_t lit;
  modport dec (output op, dest, addr, bitIdx, lit);
  modport exe (input op, dest, addr, bitIdx, lit);
endinterface
`default_nettype wire

// ==== rtl/abx_decoder.sv ====
// Instruction decoder for the execute unit
`timescale 1ns/1ps
`default_nettype none
`include "abx_params.svh"
module abx_decoder
  import abx_pkg::*;
(
  // Instruction
  input wire abx_word_t instr,
  // Decoded fields
  abx_dec_if.dec d
);
  always_comb begin
    // 14-bit word: opcode then operand fields; see RULE1
    d.lit = instr[7:0];
    d.dest = instr[7];
    d.bitIdx = instr[8:6];
    d.addr = instr[6:0];
    d.op = ABX_NONE;
    if (instr[13:8] == `ABX_OP_ADD_LIT) begin
      d.op = ABX_ADD_LIT;
    end else if (instr[13:8] == `ABX_OP_AND_LIT) begin
      d.op = ABX_AND_LIT;
    end else if (instr[13:8] == `ABX_OP_ADD_REG) begin
      d.op = ABX_ADD_REG;
    end else if (instr[13:8] == `ABX_OP_AND_REG) begin
      d.op = ABX_AND_REG;
    end else if (instr[13:9] == `ABX_OP_CLR_BIT) begin
      d.op = ABX_CLR_BIT;
      d.addr = {1'b0, instr[5:0]};
    end else if (instr[13:9] == `ABX_OP_SET_BIT) begin
      d.op = ABX_SET_BIT;
      d.addr = {1'b0, instr[5:0]};
    end
  end
endmodule
`default_nettype wire

// ==== verification/add_and_bitset_execute_unit_bench.sv ====
// Self-checking bench for the add and bit-set execute unit
`timescale 1ns/1ps
`default_nettype none
`include "abx_params.svh"
module add_and_bitset_execute_unit_bench;
  import abx_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  abx_word_t instr = 14'h0000;
  logic [6:0] peekAddr = 7'h00;
  logic [7:0] acc;
  logic [7:0] peekData;
  logic carryFlag;
  logic halfCarryFlag;
  logic zeroFlag;
  logic illegal;
  int fails = 0;
  int compares = 0;
  logic [7:0] mAcc;
  logic mC;
  logic mHalf;
  logic mZ;
  logic [7:0] mReg [0:95];
  localparam abx_word_t corners [17] = '{14'h1c10, 14'h1c15, 14'h1cda,
    14'h1c01, 14'h1c0f, 14'h1c01, 14'h1b00, 14'h1ca3, 14'h1b5f, 14'h13ff,
    14'h07bf, 14'h05bf, 14'h11ff, 14'h075f, 14'h07e0, 14'h3000, 14'h0a00};

  always #25 clock = ~clock;

  abx_exec_unit u_abx_exec_unit (
    .clock(clock), .rst(rst), .instrValid(instrValid), .instr(instr),
    .acc(acc), .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag),
    .zeroFlag(zeroFlag), .peekAddr(peekAddr), .peekData(peekData),
    .illegal(illegal));

  task automatic results();
    $display("Compares %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // Updates the reference state; returns expected illegal
  function automatic logic model(input abx_word_t w);
    logic [8:0] s;
    logic [7:0] opnd;
    logic [6:0] a;
    a = w[6:0];
    if (w[13:9] inside {`ABX_OP_CLR_BIT, `ABX_OP_SET_BIT}) begin
      mReg[w[5:0]][w[8:6]] = w[9];
      return 1'b0;
    end
    if (!(w[13:8] inside {`ABX_OP_ADD_LIT, `ABX_OP_AND_LIT,
        `ABX_OP_ADD_REG, `ABX_OP_AND_REG}) ||
        (!w[12] && a > `ABX_REG_LAST)) begin
      return 1'b1;
    end
    opnd = w[12] ? w[7:0] : mReg[a];
    if (w[13:8] inside {`ABX_OP_ADD_LIT, `ABX_OP_ADD_REG}) begin
      s = {1'b0, mAcc} + {1'b0, opnd};
      mC = s[8];
      mHalf = ({1'b0, mAcc[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f;
    end else begin
      s = {1'b0, mAcc & opnd};
    end
    mZ = s[7:0] == 8'h00;
    if (w[12] || !w[7]) begin
      mAcc = s[7:0];
    end else begin
      mReg[a] = s[7:0];
    end
    return 1'b0;
  endfunction

  function automatic abx_word_t randWord();
    logic [7:0] k;
    k = 8'($urandom);
    case ($urandom_range(5))
      0: return {`ABX_OP_ADD_LIT, k};
      1: return {`ABX_OP_AND_LIT, k};
      2: return {`ABX_OP_ADD_REG, k};
      3: return {`ABX_OP_AND_REG, k};
      4: return {`ABX_OP_CLR_BIT, k[0], k};
      default: return {`ABX_OP_SET_BIT, k[0], k};
    endcase
  endfunction

  // Valid stays high so words run back to back
  task automatic exec(input abx_word_t w);
    logic ill;
    instr = w;
    instrValid = 1'b1;
    ill = model(w);
    #1 chk1(illegal, ill);
    @(negedge clock);
    chk8(acc, mAcc);
    chk1(carryFlag, mC);
    chk1(halfCarryFlag, mHalf);
    chk1(zeroFlag, mZ);
  endtask

  // Reads back the whole file plus one address past its end
  task automatic checkRegs();
    instrValid = 1'b0;
    for (int i = 0; i < 97; i++) begin
      peekAddr = 7'(i);
      @(negedge clock);
      chk8(peekData, (i < 96) ? mReg[i] : 8'h00);
    end
  endtask

  initial begin
    mAcc = `ABX_ACC_RESET;
    mC = 1'b0;
    mHalf = 1'b0;
    mZ = 1'b0;
    mReg = '{default: `ABX_REG_RESET};
    void'($urandom(28261));
    repeat (8) @(negedge clock);
    rst = 1'b0;
    checkRegs();
    chk8(acc, mAcc);
    foreach (corners[i]) exec(corners[i]);
    checkRegs();
    repeat (400) exec(randWord());
    checkRegs();
    results();
  end

  initial begin
    #(3000 * 50);
    fails++;
    results();
  end
endmodule
`default_nettype wire
